// *** dv/cpu_move_return_op_exec_tb.sv ***
module cpu_move_return_op_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic global_interrupt_enable;
    logic [4:0] prog_idx;
    logic [12:0] prog_word;
    logic [31:0] rdata;
    logic rerr;
    logic [31:0] status;
    logic [7:0] file_init [3] = '{8'h00, 8'h11, 8'h00};
    logic [7:0] file_exp [3] = '{8'h5A, 8'h5A, 8'h00};
    int error_cnt;
    int compares;
    int edge_cnt = 0;
    int run_start;
    int run_len;

    cpu_move_return_op_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .global_interrupt_enable(global_interrupt_enable));
    prog_source partner (.index(prog_idx), .word(prog_word));

    always #5 pclk = ~pclk;

    always @(posedge pclk) edge_cnt <= edge_cnt + 1;

    task automatic test_done();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // entered just after a rising edge; answer taken at the edge that samples pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] pready expected 1 seen timeout");
            test_done();
        end
        // one idle edge keeps a following call from driving psel twice in this time step
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rdata);
    endtask : rd_chk

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        prog_idx = 5'h00;
        error_cnt = 0;
        compares = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("accumulator", exec_pkg::ACCUM_OFFSET, 32'h0);
        rd_chk("setup", exec_pkg::SETUP_OFFSET, 32'h0);
        rd_chk("status", exec_pkg::STATUS_OFFSET, 32'h0);
        chk("irq enable pin", 32'h0, {31'h0, global_interrupt_enable});
        $display("test reset done");
        // nothing lives at 0x030
        apb(1'b0, 12'h030, 32'h0);
        chk("read slverr", 32'h1, {31'h0, rerr});
        chk("read data", 32'h0, rdata);
        apb(1'b1, 12'h030, 32'h0000_00FF);
        chk("write slverr", 32'h1, {31'h0, rerr});
        $display("test unmapped done");
        for (int i = 0; i < 3; i++) begin
            wr(exec_pkg::FILE_ADDR_OFFSET, 32'(3 + i));
            wr(exec_pkg::FILE_DATA_OFFSET, {24'h0, file_init[i]});
        end
        wr(exec_pkg::PROG_ADDR_OFFSET, 32'h0);
        for (int i = 0; i < 32; i++) begin
            prog_idx = i[4:0];
            @(posedge pclk);
            wr(exec_pkg::PROG_DATA_OFFSET, {19'h0, prog_word});
        end
        // pushed so that the three returns land on 9, 11 and 13 in turn
        wr(exec_pkg::STACK_OFFSET, 32'h0000_000D);
        wr(exec_pkg::STACK_OFFSET, 32'h0000_000B);
        wr(exec_pkg::STACK_OFFSET, 32'h0000_0009);
        wr(exec_pkg::PC_OFFSET, 32'h0);
        wr(exec_pkg::CTRL_OFFSET, 32'h1);
        run_start = edge_cnt;
        repeat (16) @(posedge pclk);
        wr(exec_pkg::CTRL_OFFSET, 32'h0);
        // the core runs from the edge after the run write lands to the edge after the stop write lands
        run_len = edge_cnt - run_start;
        repeat (4) @(posedge pclk);
        apb(1'b0, exec_pkg::STATUS_OFFSET, 32'h0);
        status = rdata;
        // zero set by the last self-move of a cleared byte, enable set, undefined word seen, stack empty
        chk("status flags", 32'h0000_000B, status & 32'h7F);
        // one cycle per plain op and two per return put pc on the number of run cycles
        chk("pc after run", run_len, {20'h0, status[27:16]});
        rd_chk("cycles", exec_pkg::CYCLES_OFFSET, run_len);
        rd_chk("accumulator", exec_pkg::ACCUM_OFFSET, 32'h33);
        wr(exec_pkg::STATUS_OFFSET, 32'h0000_0008);
        apb(1'b0, exec_pkg::STATUS_OFFSET, 32'h0);
        chk("illegal cleared", 32'h3, rdata & 32'h7F);
        rd_chk("setup", exec_pkg::SETUP_OFFSET, 32'h5A);
        chk("irq enable pin", 32'h1, {31'h0, global_interrupt_enable});
        for (int i = 0; i < 3; i++) begin
            wr(exec_pkg::FILE_ADDR_OFFSET, 32'(3 + i));
            rd_chk("file", exec_pkg::FILE_DATA_OFFSET, {24'h0, file_exp[i]});
        end
        $display("test program done");
        test_done();
    end
endmodule : cpu_move_return_op_exec_tb

// *** dv/prog_source.sv ***
module prog_source (
    input wire logic [4:0] index,
    output logic [12:0] word
);
    timeunit 1ns;
    timeprecision 1ps;

    // image of the instruction words that the bench loads into program memory
    // words 8, 10 and 12 sit behind a return and are never fetched: each return jumps pc over them
    // word 6 is an undefined code: it must act as a no-operation and raise the sticky flag
    always_comb begin
        case (index)
            5'h00: word = 13'h185A;
            5'h01: word = 13'h0043;
            5'h02: word = 13'h0002;
            5'h03: word = 13'h0805;
            5'h04: word = 13'h0005;
            5'h05: word = 13'h0044;
            5'h06: word = 13'h1FFF;
            5'h07: word = 13'h1933;
            5'h08: word = 13'h18FF;
            5'h09: word = 13'h0011;
            5'h0A: word = 13'h18EE;
            5'h0B: word = 13'h0010;
            5'h0C: word = 13'h18DD;
            5'h0D: word = 13'h0843;
            5'h0E: word = 13'h0845;
            default: word = 13'h0000;
        endcase
    end
endmodule : prog_source

// *** rtl/cpu_move_return_op_exec.sv ***
module cpu_move_return_op_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic global_interrupt_enable
);
    logic [7:0] file_mem [0:exec_pkg::FILE_DEPTH-1];
    logic [12:0] prog_mem [0:exec_pkg::PROG_DEPTH-1];
    logic [11:0] stack_mem [0:exec_pkg::STACK_DEPTH-1];
    logic [2:0] sp;
    logic [11:0] pc;
    logic [7:0] accumulator;
    logic [7:0] setup_reg;
    logic zero_flag;
    logic illegal_seen;
    logic run;
    logic [5:0] prog_addr;
    logic [5:0] file_addr;
    logic [31:0] cycle_count;
    exec_pkg::state_type state;

    decode_if dec();
    op_decoder u_dec (
        .bus(dec)
    );

    // circular stack: overflow overwrites the oldest entry, underflow wraps sp from 0 round to slot 4 and reads that slot
    function automatic logic [2:0] stack_step(input logic [2:0] idx, input logic up);
        logic [2:0] last;
        last = 3'(exec_pkg::STACK_DEPTH - 1);
        if (up) begin
            stack_step = (idx == last) ? 3'h0 : idx + 3'h1;
        end else begin
            stack_step = (idx == 3'h0) ? last : idx - 3'h1;
        end
    endfunction : stack_step

    // apb: one wait state, so read data and pready both come from flops
    logic bus_wr;
    logic bus_capture;
    logic [31:0] rd_value;
    logic rd_hit;
    logic [2:0] stack_top;
    assign bus_wr = psel && penable && pready && pwrite;
    assign bus_capture = psel && penable && !pready;
    assign stack_top = stack_step(sp, 1'b0);

    always_comb begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            exec_pkg::CTRL_OFFSET: rd_value[exec_pkg::CTRL_RUN_BIT] = run;
            exec_pkg::STATUS_OFFSET: begin
                rd_value[exec_pkg::ST_ZERO_BIT] = zero_flag;
                rd_value[exec_pkg::ST_IRQ_EN_BIT] = global_interrupt_enable;
                rd_value[exec_pkg::ST_FLUSH_BIT] = (state == exec_pkg::ST_FLUSH);
                rd_value[exec_pkg::ST_ILLEGAL_BIT] = illegal_seen;
                rd_value[exec_pkg::ST_SP_LSB +: 3] = sp;
                rd_value[exec_pkg::ST_PC_LSB +: 12] = pc;
            end
            exec_pkg::ACCUM_OFFSET: rd_value[7:0] = accumulator;
            exec_pkg::SETUP_OFFSET: rd_value[7:0] = setup_reg;
            exec_pkg::PC_OFFSET: rd_value[11:0] = pc;
            exec_pkg::PROG_ADDR_OFFSET: rd_value[5:0] = prog_addr;
            exec_pkg::PROG_DATA_OFFSET: rd_value[12:0] = prog_mem[prog_addr];
            exec_pkg::FILE_ADDR_OFFSET: rd_value[5:0] = file_addr;
            exec_pkg::FILE_DATA_OFFSET: rd_value[7:0] = file_mem[file_addr];
            exec_pkg::STACK_OFFSET: rd_value[11:0] = stack_mem[stack_top];
            exec_pkg::CYCLES_OFFSET: rd_value = cycle_count;
            exec_pkg::IRQ_ENABLE_OFFSET: rd_value[0] = global_interrupt_enable;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= bus_capture;
            if (bus_capture) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_value;
                pslverr <= !rd_hit;
            end
        end
    end

    logic halted;
    logic wr_ctrl, wr_status, wr_accum, wr_setup, wr_pc, wr_prog_addr, wr_prog_data;
    logic wr_file_addr, wr_file_data, wr_stack, wr_cycles, wr_irq_en;
    assign halted = (state == exec_pkg::ST_HALT);
    assign wr_ctrl = bus_wr && paddr == exec_pkg::CTRL_OFFSET;
    assign wr_status = bus_wr && paddr == exec_pkg::STATUS_OFFSET;
    assign wr_accum = bus_wr && paddr == exec_pkg::ACCUM_OFFSET;
    assign wr_setup = bus_wr && paddr == exec_pkg::SETUP_OFFSET;
    assign wr_pc = bus_wr && paddr == exec_pkg::PC_OFFSET && halted;
    assign wr_prog_addr = bus_wr && paddr == exec_pkg::PROG_ADDR_OFFSET;
    assign wr_prog_data = bus_wr && paddr == exec_pkg::PROG_DATA_OFFSET;
    assign wr_file_addr = bus_wr && paddr == exec_pkg::FILE_ADDR_OFFSET;
    assign wr_file_data = bus_wr && paddr == exec_pkg::FILE_DATA_OFFSET;
    assign wr_stack = bus_wr && paddr == exec_pkg::STACK_OFFSET && halted;
    assign wr_cycles = bus_wr && paddr == exec_pkg::CYCLES_OFFSET;
    assign wr_irq_en = bus_wr && paddr == exec_pkg::IRQ_ENABLE_OFFSET;

    // execution: the word at pc is decoded and retired in the same cycle
    logic in_exec;
    logic is_return;
    logic [7:0] file_val;
    logic core_accum_wr;
    logic core_file_wr;
    assign dec.instr = prog_mem[pc[exec_pkg::PROG_AW-1:0]];
    assign in_exec = (state == exec_pkg::ST_EXEC);
    assign is_return = dec.op == exec_pkg::OP_RETURN || dec.op == exec_pkg::OP_INT_RETURN
        || dec.op == exec_pkg::OP_RET_LIT;
    assign file_val = file_mem[dec.reg_index];
    assign core_accum_wr = in_exec && (dec.op == exec_pkg::OP_IMM_LOAD || dec.op == exec_pkg::OP_RET_LIT
        || dec.op == exec_pkg::OP_SETUP_RD || (dec.op == exec_pkg::OP_FILE_MOVE && !dec.dest_file));
    assign core_file_wr = in_exec && (dec.op == exec_pkg::OP_ACCUM_TO_FILE
        || (dec.op == exec_pkg::OP_FILE_MOVE && dec.dest_file));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
        end else if (wr_ctrl) begin
            run <= pwdata[exec_pkg::CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= exec_pkg::ST_HALT;
        end else begin
            case (state)
                exec_pkg::ST_HALT: if (run) state <= exec_pkg::ST_EXEC;
                exec_pkg::ST_EXEC: begin
                    if (is_return) begin
                        state <= exec_pkg::ST_FLUSH; // see RL11
                    end else if (!run) begin
                        state <= exec_pkg::ST_HALT;
                    end
                end
                exec_pkg::ST_FLUSH: state <= run ? exec_pkg::ST_EXEC : exec_pkg::ST_HALT;
                default: state <= exec_pkg::ST_HALT;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= exec_pkg::PC_RESET;
        end else if (wr_pc) begin
            pc <= pwdata[11:0];
        end else if (in_exec) begin
            if (is_return) begin
                pc <= stack_mem[stack_top]; // see RL7 see RL8 see RL9
            end else begin
                pc <= pc + 12'h001; // see RL10
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= 3'h0;
        end else if (wr_stack) begin
            sp <= stack_step(sp, 1'b1);
        end else if (in_exec && is_return) begin
            sp <= stack_top;
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_stack) begin
            stack_mem[sp] <= pwdata[11:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator <= exec_pkg::ACCUM_RESET;
        end else if (core_accum_wr) begin
            case (dec.op)
                exec_pkg::OP_IMM_LOAD: accumulator <= dec.literal; // see RL2
                exec_pkg::OP_RET_LIT: accumulator <= dec.literal; // see RL9
                exec_pkg::OP_SETUP_RD: accumulator <= setup_reg; // see RL6
                default: accumulator <= file_val; // see RL3
            endcase
        end else if (wr_accum) begin
            accumulator <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_reg <= exec_pkg::SETUP_RESET;
        end else if (in_exec && dec.op == exec_pkg::OP_SETUP_WR) begin
            setup_reg <= accumulator; // see RL5
        end else if (wr_setup) begin
            setup_reg <= pwdata[7:0];
        end
    end

    // core write wins over a software write to the same file in that cycle
    always_ff @(posedge pclk) begin
        if (core_file_wr) begin
            file_mem[dec.reg_index] <= (dec.op == exec_pkg::OP_ACCUM_TO_FILE) ? accumulator : file_val; // see RL1 see RL3
        end else if (wr_file_data) begin
            file_mem[file_addr] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_prog_data) begin
            prog_mem[prog_addr] <= pwdata[12:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr <= 6'h00;
            file_addr <= 6'h00;
        end else begin
            if (wr_prog_addr) begin
                prog_addr <= pwdata[5:0];
            end else if (wr_prog_data) begin
                prog_addr <= prog_addr + 6'h01;
            end
            if (wr_file_addr) begin
                file_addr <= pwdata[5:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_flag <= 1'b0;
        end else if (in_exec && dec.op == exec_pkg::OP_FILE_MOVE) begin
            zero_flag <= (file_val == 8'h00); // see RL4
        end
    end

    // hardware set wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_interrupt_enable <= exec_pkg::IRQ_ENABLE_RESET;
        end else if (in_exec && dec.op == exec_pkg::OP_INT_RETURN) begin
            global_interrupt_enable <= 1'b1; // see RL8
        end else if (wr_irq_en) begin
            global_interrupt_enable <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            illegal_seen <= 1'b0;
        end else if (in_exec && dec.op == exec_pkg::OP_ILLEGAL) begin
            illegal_seen <= 1'b1;
        end else if (wr_status && pwdata[exec_pkg::ST_ILLEGAL_BIT]) begin
            illegal_seen <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_count <= 32'h0000_0000;
        end else if (wr_cycles) begin
            cycle_count <= 32'h0000_0000;
        end else if (!halted) begin
            cycle_count <= cycle_count + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic accum_quiet;
    assign accum_quiet = !wr_accum;

    chk_accum_file_move: assert property ( // see RL1
        in_exec && dec.op == exec_pkg::OP_ACCUM_TO_FILE && !wr_file_data
        |=> file_mem[$past(dec.reg_index)] == $past(accumulator) && $stable(zero_flag))
        else $error("accumulator to file move did not copy accumulator");
    chk_imm_load: assert property ( // see RL2
        in_exec && dec.op == exec_pkg::OP_IMM_LOAD |=> accumulator == $past(dec.literal) && $stable(zero_flag))
        else $error("immediate load wrong");
    chk_file_move_dest: assert property ( // see RL3
        in_exec && dec.op == exec_pkg::OP_FILE_MOVE |=>
        ($past(dec.dest_file) ? (file_mem[$past(dec.reg_index)] == $past(file_val))
                              : (accumulator == $past(file_val))))
        else $error("file move destination wrong");
    chk_zero_test: assert property ( // see RL4
        in_exec && dec.op == exec_pkg::OP_FILE_MOVE && run |=> zero_flag == ($past(file_val) == 8'h00) && in_exec)
        else $error("file move zero flag or timing wrong");
    chk_setup_write: assert property ( // see RL5
        in_exec && dec.op == exec_pkg::OP_SETUP_WR |=> setup_reg == $past(accumulator) && $stable(zero_flag))
        else $error("setup write wrong");
    chk_setup_read: assert property ( // see RL6
        in_exec && dec.op == exec_pkg::OP_SETUP_RD |=> accumulator == $past(setup_reg) && $stable(zero_flag))
        else $error("setup read wrong");
    chk_return_pop: assert property ( // see RL7
        in_exec && dec.op == exec_pkg::OP_RETURN |=> pc == $past(stack_mem[stack_top])
        && state == exec_pkg::ST_FLUSH ##1 state != exec_pkg::ST_FLUSH)
        else $error("return did not pop in two cycles");
    chk_int_return_gie: assert property ( // see RL8
        in_exec && dec.op == exec_pkg::OP_INT_RETURN |=> global_interrupt_enable && state == exec_pkg::ST_FLUSH
        && pc == $past(stack_mem[stack_top]))
        else $error("interrupt return did not set enable");
    chk_ret_literal: assert property ( // see RL9
        in_exec && dec.op == exec_pkg::OP_RET_LIT |=> accumulator == $past(dec.literal)
        && pc == $past(stack_mem[stack_top]) && $stable(zero_flag))
        else $error("return with literal wrong");
    chk_nop_quiet: assert property ( // see RL10
        in_exec && dec.op == exec_pkg::OP_NOP && accum_quiet && !wr_setup |=> pc == $past(pc) + 12'h001
        && $stable(accumulator) && $stable(zero_flag) && $stable(setup_reg))
        else $error("no-operation changed state");
    chk_flush_discard: assert property ( // see RL11
        state == exec_pkg::ST_FLUSH && accum_quiet && !wr_setup |=> $stable(pc) && $stable(accumulator)
        && $stable(setup_reg) && $stable(zero_flag))
        else $error("flushed instruction took effect");

    cov_return: cover property (in_exec && dec.op == exec_pkg::OP_RETURN ##2 in_exec);
    cov_int_return: cover property (in_exec && dec.op == exec_pkg::OP_INT_RETURN);
    cov_zero_test: cover property (in_exec && dec.op == exec_pkg::OP_FILE_MOVE && dec.dest_file && file_val == 8'h00);
    cov_apb_error: cover property (pready && pslverr);
endmodule : cpu_move_return_op_exec

// *** rtl/decode_if.sv ***
interface decode_if;
    logic [12:0] instr;
    exec_pkg::op_type op;
    logic [5:0] reg_index;
    logic dest_file;
    logic [7:0] literal;
    modport requester(output instr, input op, input reg_index, input dest_file, input literal);
    modport decoder(input instr, output op, output reg_index, output dest_file, output literal);
endinterface : decode_if

// *** rtl/exec_pkg.sv ***
// Operation
// RL1: accumulator-to-file move copies accumulator into file register in one cycle, flags kept.
// RL2: immediate load puts 8-bit literal into accumulator in one cycle, flags kept.
// RL3: file move reads register 0..63, writes accumulator (d=0) or same register (d=1).
// RL4: file move sets zero flag from moved value in one cycle; self-move tests zero.
// RL5: setup-register write copies accumulator into setup register in one cycle, flags kept.
// RL6: setup-register read copies setup register into accumulator in one cycle, flags kept.
// RL7: plain return pops stack top into program counter in two cycles, flags kept.
// RL8: interrupt return pops program counter and sets global interrupt enable, two cycles.
// RL9: return with literal loads 8-bit literal into accumulator and pops counter, two cycles.
// RL10: no-operation takes one cycle, advances program counter, changes nothing else.
// RL11: two-cycle returns discard the already fetched next instruction in cycle two.
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int INSTR_W = 13;
    localparam int FILE_DEPTH = 64;
    localparam int PROG_AW = 6;
    localparam int PROG_DEPTH = 64;
    localparam int STACK_DEPTH = 5;
    localparam int SP_W = 3;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] ACCUM_OFFSET = 12'h008;
    localparam logic [11:0] SETUP_OFFSET = 12'h00C;
    localparam logic [11:0] PC_OFFSET = 12'h010;
    localparam logic [11:0] PROG_ADDR_OFFSET = 12'h014;
    localparam logic [11:0] PROG_DATA_OFFSET = 12'h018;
    localparam logic [11:0] FILE_ADDR_OFFSET = 12'h01C;
    localparam logic [11:0] FILE_DATA_OFFSET = 12'h020;
    localparam logic [11:0] STACK_OFFSET = 12'h024;
    localparam logic [11:0] CYCLES_OFFSET = 12'h028;
    localparam logic [11:0] IRQ_ENABLE_OFFSET = 12'h02C;

    // status field positions
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_IRQ_EN_BIT = 1;
    localparam int ST_FLUSH_BIT = 2;
    localparam int ST_ILLEGAL_BIT = 3;
    localparam int ST_SP_LSB = 4;
    localparam int ST_PC_LSB = 16;
    localparam int CTRL_RUN_BIT = 0;

    // reset values
    localparam logic [7:0] ACCUM_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic IRQ_ENABLE_RESET = 1'b0;

    // instruction encodings: match value and mask
    localparam logic [12:0] ENC_NOP = 13'h0000;
    localparam logic [12:0] ENC_SETUP_WR = 13'h0002;
    localparam logic [12:0] ENC_SETUP_RD = 13'h0005;
    localparam logic [12:0] ENC_RETURN = 13'h0010;
    localparam logic [12:0] ENC_INT_RETURN = 13'h0011;
    localparam logic [12:0] ENC_ACCUM_TO_FILE = 13'h0040;
    localparam logic [12:0] MASK_ACCUM_TO_FILE = 13'h1FC0;
    localparam logic [12:0] ENC_FILE_MOVE = 13'h0800;
    localparam logic [12:0] MASK_FILE_MOVE = 13'h1F80;
    localparam logic [12:0] ENC_IMM_LOAD = 13'h1800;
    localparam logic [12:0] ENC_RET_LIT = 13'h1900;
    localparam logic [12:0] MASK_LITERAL = 13'h1F00;
    localparam int DEST_BIT = 6;

    typedef enum logic [3:0] {
        OP_NOP, OP_ACCUM_TO_FILE, OP_FILE_MOVE, OP_IMM_LOAD, OP_SETUP_WR,
        OP_SETUP_RD, OP_RETURN, OP_INT_RETURN, OP_RET_LIT, OP_ILLEGAL
    } op_type;

    typedef enum logic [1:0] {
        ST_HALT = 2'b00,
        ST_EXEC = 2'b01,
        ST_FLUSH = 2'b11
    } state_type;
endpackage : exec_pkg

// *** rtl/op_decoder.sv ***
module op_decoder (
    decode_if.decoder bus
);
    always_comb begin
        bus.reg_index = bus.instr[5:0];
        bus.dest_file = bus.instr[exec_pkg::DEST_BIT];
        bus.literal = bus.instr[7:0];
        if (bus.instr == exec_pkg::ENC_NOP) begin
            bus.op = exec_pkg::OP_NOP;
        end else if (bus.instr == exec_pkg::ENC_SETUP_WR) begin
            bus.op = exec_pkg::OP_SETUP_WR;
        end else if (bus.instr == exec_pkg::ENC_SETUP_RD) begin
            bus.op = exec_pkg::OP_SETUP_RD;
        end else if (bus.instr == exec_pkg::ENC_RETURN) begin
            bus.op = exec_pkg::OP_RETURN;
        end else if (bus.instr == exec_pkg::ENC_INT_RETURN) begin
            bus.op = exec_pkg::OP_INT_RETURN;
        end else if ((bus.instr & exec_pkg::MASK_ACCUM_TO_FILE) == exec_pkg::ENC_ACCUM_TO_FILE) begin
            bus.op = exec_pkg::OP_ACCUM_TO_FILE;
        end else if ((bus.instr & exec_pkg::MASK_FILE_MOVE) == exec_pkg::ENC_FILE_MOVE) begin
            bus.op = exec_pkg::OP_FILE_MOVE;
        end else if ((bus.instr & exec_pkg::MASK_LITERAL) == exec_pkg::ENC_IMM_LOAD) begin
            bus.op = exec_pkg::OP_IMM_LOAD;
        end else if ((bus.instr & exec_pkg::MASK_LITERAL) == exec_pkg::ENC_RET_LIT) begin
            bus.op = exec_pkg::OP_RET_LIT;
        end else begin
            bus.op = exec_pkg::OP_ILLEGAL;
        end
    end
endmodule : op_decoder
